// ---- bench/svf_deser_model.sv ----
module svf_deser_model
  import svf_pkg::*;
(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // Serial from the framer, fault request
  input  wire logic             i_ser_bit,
  input  wire logic             i_ser_valid,
  input  wire logic             i_ser_first,
  input  wire logic [4:0]       i_flip_pos,
  // Serial back to the framer, captured word
  output logic                  o_rx_bit,
  output logic                  o_rx_valid,
  output logic                  o_rx_first,
  output logic [SER_W-1:0]      o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pos_ff;
  logic       last_ff;
  wire logic [4:0] cur = i_ser_first ? 5'h01 : pos_ff;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos_ff <= 5'h00;
      o_word <= '0;
    end else if (i_ser_valid) begin
      pos_ff <= cur + 5'h01;
      if (i_ser_first) o_word <= {{(SER_W-1){1'b0}}, i_ser_bit};
      else o_word[cur-5'h01] <= i_ser_bit;
    end
  end
  // Idle line toggles so a stale level is never mistaken for data
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= o_rx_bit;
    end
  end
  assign o_rx_bit   = i_ser_valid ? (i_ser_bit ^ (cur == i_flip_pos)) : ~last_ff;
  assign o_rx_valid = i_ser_valid;
  assign o_rx_first = i_ser_first;
endmodule

// ---- bench/svf_framer_asserts.sv ----
module svf_framer_asserts
  import svf_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hready,
  input wire logic        i_pix_valid,
  input wire logic        i_rx_valid,
  input wire logic        i_rx_first,
  // Outputs
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_pix_ready,
  input wire logic        o_ser_valid,
  input wire logic        o_ser_first,
  input wire logic        o_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  a_bus_wait: assert property (take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("wait state not exactly one cycle");
  a_bus_idle: assert property (o_hreadyout && !take |=> o_hreadyout)
    else $error("hreadyout fell without a transfer");
  a_rdata_zero: assert property ($past(o_hreadyout) && o_hreadyout |-> o_hrdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_resp_okay: assert property (o_hresp == HRESP_OKAY)
    else $error("response not okay");
  a_word_start: assert property (i_pix_valid && o_pix_ready
    |=> (!o_pix_ready && !o_ser_valid) ##1 (o_ser_valid && o_ser_first))
    else $error("word did not start after take");
  a_bits_run: assert property (o_ser_valid && !o_pix_ready |=> o_ser_valid)
    else $error("gap inside a serial word");
  a_word_min: assert property (o_ser_first |=> (o_ser_valid && !o_ser_first)[*8])
    else $error("serial word too short");
  a_rx_quiet: assert property (i_rx_valid && i_rx_first |=> ##1 (!o_rx_valid)[*8])
    else $error("recovered word too early");
endmodule

bind svf_framer svf_framer_asserts u_svf_framer_asserts (
  .i_core_clk  (i_core_clk),
  .i_sys_rst   (i_sys_rst),
  .i_hsel      (i_hsel),
  .i_htrans    (i_htrans),
  .i_hready    (i_hready),
  .i_pix_valid (i_pix_valid),
  .i_rx_valid  (i_rx_valid),
  .i_rx_first  (i_rx_first),
  .o_hrdata    (o_hrdata),
  .o_hreadyout (o_hreadyout),
  .o_hresp     (o_hresp),
  .o_pix_ready (o_pix_ready),
  .o_ser_valid (o_ser_valid),
  .o_ser_first (o_ser_first),
  .o_rx_valid  (o_rx_valid)
);

// ---- bench/svf_framer_test.sv ----
module svf_framer_test
  import svf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, hsel, hwrite, pix_valid, prbs_err;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [4:0] link_err, flip;
  svf_pixel_t pix, rx_pix;
  logic hreadyout, hresp, pix_ready, ser_bit, ser_valid, ser_first, rx_bit, rx_valid, rx_first, rxv, perr_over, irq;
  logic [SER_W-1:0] word;
  int error_cnt, n_tests;

  svf_framer u_svf_framer (.i_core_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_pix_valid(pix_valid), .i_pix(pix), .o_pix_ready(pix_ready),
    .o_ser_bit(ser_bit), .o_ser_valid(ser_valid), .o_ser_first(ser_first), .i_rx_bit(rx_bit),
    .i_rx_valid(rx_valid), .i_rx_first(rx_first), .o_rx_pix(rx_pix), .o_rx_valid(rxv),
    .i_prbs_err(prbs_err), .i_link_err(link_err), .o_perr_over(perr_over), .o_irq(irq));
  svf_deser_model u_svf_deser_model (.i_core_clk(clk), .i_sys_rst(rst), .i_ser_bit(ser_bit),
    .i_ser_valid(ser_valid), .i_ser_first(ser_first), .i_flip_pos(flip), .o_rx_bit(rx_bit),
    .o_rx_valid(rx_valid), .o_rx_first(rx_first), .o_word(word));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task hang;
    error_cnt++;
    conclude();
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address phase held until hready, data taken at the edge ending the data phase
  task bus(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, idx, 2'b00};
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) hang();
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task rdchk(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(x, {24'h000000, e});
  endtask
  task send(input svf_pixel_t p);
    int n;
    n = 0;
    @(posedge clk);
    pix_valid <= 1'b1;
    pix <= p;
    do begin @(posedge clk); n++; end while (pix_ready !== 1'b1 && n < 50);
    pix_valid <= 1'b0;
    do begin @(posedge clk); n++; end while (rxv !== 1'b1 && n < 80);
    if (n >= 80) hang();
  endtask
  function automatic logic [31:0] exp_word(input logic [3:0] cfg, input svf_pixel_t p);
    logic [19:0] w;
    w = '0;
    w[0] = ENC_BIT_ZERO_VAL;
    w[1] = ENC_BIT_ONE_VAL;
    w[2] = p.line_sync;
    w[3] = p.frame_sync;
    for (int i = 0; i < (cfg[2] ? 16 : 8 + 2 * cfg[1:0]); i++) w[4+i] = p.video[i];
    if (cfg[3] && !cfg[2]) w = {w[17:0], ~(^w), ^w};
    return {12'h000, w};
  endfunction

  task t_regs;
    rdchk(IDX_CONFIG, CONFIG_RST);
    rdchk(IDX_ERR_CTRL, ERR_CTRL_RST);
    rdchk(IDX_THR_LO, 8'h10);
    rdchk(IDX_THR_HI, 8'h00);
    rdchk(IDX_PERR_LO, 8'h00);
    rdchk(IDX_PERR_HI, 8'h00);
    rdchk(IDX_PRBS_ERR, 8'h00);
    rdchk(IDX_LINK_ERR, 8'h00);
    rdchk(6'h3F, 8'h00);
    wr(IDX_PERR_LO, 8'hFF);
    rdchk(IDX_PERR_LO, 8'h00);
    wr(IDX_THR_HI, 8'h5A);
    rdchk(IDX_THR_HI, 8'h5A);
    wr(IDX_THR_HI, 8'h00);
    wr(IDX_THR_LO, 8'h01);
    $display("registers done");
  endtask
  task t_fmt;
    logic [3:0] cfg;
    svf_pixel_t p;
    logic [15:0] vm;
    logic [31:0] ew;
    for (int c = 0; c < 10; c++) begin
      cfg = {c >= 5, (c % 5 == 4) ? 3'b100 : 3'(c % 5)};
      p = '{video: 16'hA5C3 ^ 16'(c), frame_sync: c[0], line_sync: ~c[0]};
      vm = cfg[2] ? 16'hFFFF : 16'((32'h1 << (8 + 2 * cfg[1:0])) - 1);
      wr(IDX_CONFIG, {4'h0, cfg});
      send(p);
      ew = exp_word(cfg, p);
      check({12'h000, word}, ew);
      check({30'h0, word[1:0]}, {30'h0, ew[1:0]});
      check({14'h0, rx_pix}, {14'h0, p.video & vm, p.frame_sync, p.line_sync});
    end
    $display("formats done");
  endtask
  task t_errs;
    repeat (3) begin
      @(posedge clk) prbs_err <= 1'b1;
      @(posedge clk) prbs_err <= 1'b0;
    end
    rdchk(IDX_PRBS_ERR, 8'h03);
    rdchk(IDX_PRBS_ERR, 8'h00);
    @(posedge clk) link_err <= 5'h15;
    repeat (3) @(posedge clk);
    link_err <= 5'h00;
    rdchk(IDX_LINK_ERR, 8'h15);
    rdchk(IDX_LINK_ERR, 8'h00);
    $display("error counters done");
  endtask
  task t_par;
    svf_pixel_t p;
    p = '{video: 16'h1234, frame_sync: 1'b1, line_sync: 1'b0};
    wr(IDX_CONFIG, 8'h0B);
    wr(IDX_IRQ_MASK, 8'h01);
    rdchk(IDX_IRQ_MASK, 8'h01);
    flip <= 5'h05;
    send(p);
    flip <= 5'h00;
    repeat (2) @(posedge clk);
    check({31'h0, perr_over}, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdchk(IDX_PERR_LO, 8'h01);
    rdchk(IDX_PERR_HI, 8'h00);
    rdchk(IDX_PERR_LO, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, perr_over}, 32'h0);
    rdchk(IDX_IRQ_STAT, 8'h0F);
    wr(IDX_IRQ_STAT, 8'h01);
    rdchk(IDX_IRQ_STAT, 8'h0E);
    wr(IDX_IRQ_STAT, 8'h0E);
    rdchk(IDX_IRQ_STAT, 8'h00);
    wr(IDX_ERR_CTRL, 8'h20);
    flip <= 5'h09;
    send(p);
    flip <= 5'h00;
    rdchk(IDX_PERR_LO, 8'h01);
    rdchk(IDX_PERR_LO, 8'h01);
    $display("parity done");
  endtask

  initial begin
    rst = 1'b1;
    {hsel, hwrite, pix_valid, prbs_err} = 4'h0;
    {haddr, hwdata} = '0;
    htrans = 2'b00;
    {link_err, flip} = '0;
    pix = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fmt();
    t_errs();
    t_par();
    conclude();
  end
endmodule

// ---- rtl/svf_framer.sv ----
module svf_framer
  import svf_pkg::*;
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic [31:0]            o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Parallel video in
  input  wire logic              i_pix_valid,
  input  wire svf_pixel_t        i_pix,
  output logic                   o_pix_ready,
  // Serial out
  output logic                   o_ser_bit,
  output logic                   o_ser_valid,
  output logic                   o_ser_first,
  // Serial in
  input  wire logic              i_rx_bit,
  input  wire logic              i_rx_valid,
  input  wire logic              i_rx_first,
  // Recovered video out
  output svf_pixel_t             o_rx_pix,
  output logic                   o_rx_valid,
  // Error sources and indications
  input  wire logic              i_prbs_err,
  input  wire logic [LINK_W-1:0] i_link_err,
  output logic                   o_perr_over,
  output logic                   o_irq
);

  logic [7:0]        config_ff;
  logic [7:0]        err_ctrl_ff;
  logic [15:0]       thr_ff;
  logic [15:0]       perr_ff;
  logic [7:0]        perr_hi_shadow_ff;
  logic              shadow_valid_ff;
  logic [7:0]        prbs_ff;
  logic [LINK_W-1:0] link_ff;
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;

  logic              dph_ff;
  logic              dph_write_ff;
  logic [5:0]        dph_idx_ff;
  logic [31:0]       hrdata_ff;
  logic              hreadyout_ff;

  logic [SER_W-1:0]  tx_shift_ff;
  logic [CNT_W-1:0]  tx_left_ff;
  logic              tx_first_ff;
  logic              pix_ready_ff;
  logic              ser_bit_ff;
  logic              ser_valid_ff;
  logic              ser_first_ff;

  logic [SER_W-1:0]  rx_shift_ff;
  logic [CNT_W-1:0]  rx_cnt_ff;
  svf_pixel_t        rx_pix_ff;
  logic              rx_valid_ff;
  logic              perr_over_ff;
  logic              irq_ff;

  // Configuration decode
  logic [CNT_W-1:0]  vid_bits;
  logic              par_on;
  logic [CNT_W-1:0]  ser_len;
  logic              auto_reset;
  logic [SER_W-1:0]  len_mask;
  logic [SER_W-1:0]  core_mask;

  assign vid_bits   = svf_video_bits(config_ff[CFG_PARALLEL_WIDTH_SELECT_LSB +: 3]);
  // Parity bits only below the widest word
  assign par_on     = config_ff[CFG_PARITY_ENABLE_BIT] && (vid_bits != 5'h10);
  // Serial length from width and parity
  assign ser_len    = vid_bits + CNT_W'(HDR_BITS) + (par_on ? CNT_W'(PAR_BITS) : 5'h00);
  assign auto_reset = err_ctrl_ff[ERR_AER_BIT];
  assign core_mask  = par_on ? (len_mask >> PAR_BITS) : len_mask;

  // One mask bit per serial position
  for (genvar gi = 0; gi < SER_W; gi++) begin : g_len_mask
    assign len_mask[gi] = (CNT_W'(gi) < ser_len);
  end

  // Parity bits ahead of the core
  function automatic logic [SER_W-1:0] build_word(input svf_pixel_t p, input logic par,
                                                 input logic [SER_W-1:0] cmask,
                                                 input logic [SER_W-1:0] lmask);
    logic [SER_W-1:0] core;
    logic             pb;
    core = {p.video, p.frame_sync, p.line_sync, ENC_BIT_ONE_VAL, ENC_BIT_ZERO_VAL} & cmask;
    pb   = ^core;
    if (par) begin
      return {core[SER_W-PAR_BITS-1:0], ~pb, pb} & lmask;
    end else begin
      return core & lmask;
    end
  endfunction

  // Transmit path
  logic tx_load;
  assign tx_load = i_pix_valid && pix_ready_ff;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_shift_ff  <= '0;
      tx_left_ff   <= '0;
      tx_first_ff  <= 1'b0;
      pix_ready_ff <= 1'b1;
      ser_bit_ff   <= 1'b0;
      ser_valid_ff <= 1'b0;
      ser_first_ff <= 1'b0;
    end else if (tx_load) begin
      tx_shift_ff  <= build_word(i_pix, par_on, core_mask, len_mask);
      tx_left_ff   <= ser_len;
      tx_first_ff  <= 1'b1;
      pix_ready_ff <= 1'b0;
      ser_valid_ff <= 1'b0;
      ser_first_ff <= 1'b0;
    end else if (tx_left_ff != '0) begin
      ser_bit_ff   <= tx_shift_ff[0];
      ser_valid_ff <= 1'b1;
      ser_first_ff <= tx_first_ff;
      tx_first_ff  <= 1'b0;
      tx_shift_ff  <= tx_shift_ff >> 1;
      tx_left_ff   <= tx_left_ff - 5'h01;
      pix_ready_ff <= (tx_left_ff == 5'h01);
    end else begin
      ser_valid_ff <= 1'b0;
      ser_first_ff <= 1'b0;
    end
  end

  // Receive path
  // A new first bit restarts the count, so a cut word is simply dropped
  logic [SER_W-1:0] rx_word;
  logic [SER_W-1:0] rx_core;
  logic [CNT_W-1:0] rx_pos;
  logic             rx_done;
  logic             rx_par_bad;

  always_comb begin
    rx_pos          = i_rx_first ? '0 : rx_cnt_ff;
    rx_word         = rx_shift_ff;
    rx_word[rx_pos] = i_rx_bit;
    rx_done         = i_rx_valid && ((rx_pos + 5'h01) == ser_len);
    rx_core         = (par_on ? (rx_word >> PAR_BITS) : rx_word) & core_mask;
    // Both parity bits must agree with the core
    rx_par_bad      = par_on && ((rx_word[0] != ^rx_core) || (rx_word[1] == ^rx_core));
  end

  // Bits land at rising positions from the word start
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_shift_ff <= '0;
      rx_cnt_ff   <= '0;
      rx_pix_ff   <= '0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= rx_done;
      if (i_rx_valid) begin
        rx_shift_ff <= rx_done ? '0 : rx_word;
        rx_cnt_ff   <= rx_done ? '0 : rx_pos + 5'h01;
      end
      if (rx_done) begin
        rx_pix_ff.line_sync  <= rx_core[2];
        rx_pix_ff.frame_sync <= rx_core[3];
        rx_pix_ff.video      <= rx_core[SER_W-1:HDR_BITS];
      end
    end
  end

  // Bus decode
  logic        addr_take;
  logic        wr_now;
  logic        rd_now;
  logic [7:0]  wbyte;
  logic        rd_clr_perr;
  logic        rd_clr_perr_hi;
  logic        rd_clr_prbs;
  logic        rd_clr_link;
  logic        perr_ev;
  logic [15:0] perr_inc;

  assign addr_take      = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  assign wr_now         = dph_ff && dph_write_ff;
  assign rd_now         = dph_ff && !dph_write_ff;
  assign wbyte          = i_hwdata[7:0];
  // Reads clear counts unless auto reset is set
  assign rd_clr_perr    = rd_now && !auto_reset && (dph_idx_ff == IDX_PERR_LO);
  assign rd_clr_perr_hi = rd_now && (dph_idx_ff == IDX_PERR_HI);
  assign rd_clr_prbs    = rd_now && !auto_reset && (dph_idx_ff == IDX_PRBS_ERR);
  assign rd_clr_link    = rd_now && !auto_reset && (dph_idx_ff == IDX_LINK_ERR);
  assign perr_ev        = rx_done && rx_par_bad;
  assign perr_inc       = (perr_ff == 16'hFFFF) ? perr_ff : perr_ff + 16'h0001;

  // One wait state: address phase, then data phase with registered answer
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dph_ff       <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_idx_ff   <= '0;
      hreadyout_ff <= 1'b1;
    end else begin
      dph_ff       <= addr_take;
      hreadyout_ff <= !addr_take;
      if (addr_take) begin
        dph_write_ff <= i_hwrite;
        dph_idx_ff   <= i_haddr[IDX_LSB +: 6];
      end
    end
  end

  // Read data, unmapped reads answer zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hrdata_ff <= '0;
    end else if (rd_now) begin
      case (dph_idx_ff)
        IDX_CONFIG:   hrdata_ff <= {24'h000000, config_ff};
        IDX_ERR_CTRL: hrdata_ff <= {24'h000000, err_ctrl_ff};
        IDX_THR_LO:   hrdata_ff <= {24'h000000, thr_ff[7:0]};
        IDX_THR_HI:   hrdata_ff <= {24'h000000, thr_ff[15:8]};
        IDX_PERR_LO:  hrdata_ff <= {24'h000000, perr_ff[7:0]};
        IDX_PERR_HI:  hrdata_ff <= {24'h000000, shadow_valid_ff ? perr_hi_shadow_ff : perr_ff[15:8]};
        IDX_PRBS_ERR: hrdata_ff <= {24'h000000, prbs_ff};
        IDX_LINK_ERR: hrdata_ff <= {24'h000000, 3'b000, link_ff};
        IDX_IRQ_STAT: hrdata_ff <= {28'h0000000, irq_stat_ff};
        IDX_IRQ_MASK: hrdata_ff <= {28'h0000000, irq_mask_ff};
        default:      hrdata_ff <= '0;
      endcase
    end else begin
      hrdata_ff <= '0;
    end
  end

  // Writable configuration
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      config_ff   <= CONFIG_RST;
      err_ctrl_ff <= ERR_CTRL_RST;
      thr_ff      <= {THR_HI_RST, THR_LO_RST};
      irq_mask_ff <= '0;
    end else if (wr_now) begin
      case (dph_idx_ff)
        IDX_CONFIG:   config_ff   <= wbyte;
        IDX_ERR_CTRL: err_ctrl_ff <= wbyte;
        IDX_THR_LO:   thr_ff[7:0]  <= wbyte;
        IDX_THR_HI:   thr_ff[15:8] <= wbyte;
        IDX_IRQ_MASK: irq_mask_ff  <= wbyte[IRQ_W-1:0];
        default:      config_ff    <= config_ff;
      endcase
    end
  end

  // Video parity error counter, a new error beats a clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      perr_ff           <= '0;
      perr_hi_shadow_ff <= '0;
      shadow_valid_ff   <= 1'b0;
    end else begin
      if (rd_clr_perr) begin
        perr_ff <= perr_ev ? 16'h0001 : 16'h0000;
      end else if (perr_ev) begin
        perr_ff <= perr_inc;
      end
      // High byte held from the clearing low read so the pair stays coherent
      if (rd_clr_perr) begin
        perr_hi_shadow_ff <= perr_ff[15:8];
        shadow_valid_ff   <= 1'b1;
      end else if (rd_clr_perr_hi) begin
        shadow_valid_ff   <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prbs_ff <= '0;
    end else if (rd_clr_prbs) begin
      prbs_ff <= i_prbs_err ? 8'h01 : 8'h00;
    end else if (i_prbs_err && (prbs_ff != 8'hFF)) begin
      prbs_ff <= prbs_ff + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_ff <= '0;
    end else if (rd_clr_link) begin
      link_ff <= i_link_err;
    end else begin
      link_ff <= link_ff | i_link_err;
    end
  end

  // Interrupt status, write one to clear, set wins
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_PERR] = perr_ev;
    // Event when the count reaches the threshold
    irq_set[IRQ_THR]  = perr_ev && !rd_clr_perr && (perr_inc == thr_ff) && (perr_ff != thr_ff);
    irq_set[IRQ_PRBS] = i_prbs_err;
    irq_set[IRQ_LINK] = |(i_link_err & ~link_ff);
    irq_clr           = (wr_now && (dph_idx_ff == IDX_IRQ_STAT)) ? wbyte[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_ff  <= '0;
      irq_ff       <= 1'b0;
      perr_over_ff <= 1'b0;
    end else begin
      irq_stat_ff  <= (irq_stat_ff & ~irq_clr) | irq_set;
      irq_ff       <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
      perr_over_ff <= (perr_ff >= thr_ff);
    end
  end

  assign o_hrdata    = hrdata_ff;
  assign o_hreadyout = hreadyout_ff;
  // Word-only slave with no error cases, so the response stays OKAY
  assign o_hresp     = HRESP_OKAY;
  assign o_pix_ready = pix_ready_ff;
  assign o_ser_bit   = ser_bit_ff;
  assign o_ser_valid = ser_valid_ff;
  assign o_ser_first = ser_first_ff;
  assign o_rx_pix    = rx_pix_ff;
  assign o_rx_valid  = rx_valid_ff;
  assign o_perr_over = perr_over_ff;
  assign o_irq       = irq_ff;

endmodule

// ---- rtl/svf_pkg.sv ----
package svf_pkg;

  // Word geometry
  localparam int unsigned SER_W     = 20;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned VID_W     = 16;
  localparam int unsigned HDR_BITS  = 4;
  localparam int unsigned PAR_BITS  = 2;
  localparam int unsigned LINK_W    = 5;

  // Fixed encoding-bit values (marker pattern, high then low)
  localparam logic        ENC_BIT_ZERO_VAL = 1'b1;
  localparam logic        ENC_BIT_ONE_VAL  = 1'b0;

  // Register indexes; byte address is four times the index
  localparam logic [5:0]  IDX_CONFIG    = 6'h00;
  localparam logic [5:0]  IDX_ERR_CTRL  = 6'h01;
  localparam logic [5:0]  IDX_THR_LO    = 6'h08;
  localparam logic [5:0]  IDX_THR_HI    = 6'h09;
  localparam logic [5:0]  IDX_PERR_LO   = 6'h0A;
  localparam logic [5:0]  IDX_PERR_HI   = 6'h0B;
  localparam logic [5:0]  IDX_PRBS_ERR  = 6'h0C;
  localparam logic [5:0]  IDX_LINK_ERR  = 6'h0D;
  localparam logic [5:0]  IDX_IRQ_STAT  = 6'h10;
  localparam logic [5:0]  IDX_IRQ_MASK  = 6'h11;
  localparam int unsigned IDX_LSB       = 2;

  // Reset values
  localparam logic [7:0]  CONFIG_RST    = 8'hB5;
  localparam logic [7:0]  ERR_CTRL_RST  = 8'h00;
  localparam logic [7:0]  THR_LO_RST    = 8'h10;
  localparam logic [7:0]  THR_HI_RST    = 8'h00;

  // Field positions
  localparam int unsigned CFG_PARITY_ENABLE_BIT  = 3;
  localparam int unsigned CFG_PARALLEL_WIDTH_SELECT_LSB = 0;
  localparam int unsigned ERR_AER_BIT    = 5;

  // Interrupt status bits
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_PERR     = 0;
  localparam int unsigned IRQ_THR      = 1;
  localparam int unsigned IRQ_PRBS     = 2;
  localparam int unsigned IRQ_LINK     = 3;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic [VID_W-1:0] video;
    logic             frame_sync;
    logic             line_sync;
  } svf_pixel_t;

  typedef enum logic [2:0] {
    svf_pw_10 = 3'b000,
    svf_pw_12 = 3'b001,
    svf_pw_14 = 3'b010,
    svf_pw_16 = 3'b011
  } svf_parallel_width_select_t;

  // Video bits per parallel width code: 8,10,12,14 and 16 for 1xx
  function automatic logic [CNT_W-1:0] svf_video_bits(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = 5'h10;
    case (code)
      svf_pw_10: n = 5'h08;
      svf_pw_12: n = 5'h0A;
      svf_pw_14: n = 5'h0C;
      svf_pw_16: n = 5'h0E;
      default:   n = 5'h10;
    endcase
    return n;
  endfunction

endpackage
